// ==== hw/iocmd_pkg.sv ====
// Package: register map, field positions and types of the command decoder
package iocmd_pkg;
	localparam logic [7:0] OFS_IDENT   = 8'h00;
	localparam logic [7:0] OFS_RDATA   = 8'h04;
	localparam logic [7:0] OFS_STWORD  = 8'h08;
	localparam logic [7:0] OFS_CTRL    = 8'h0c;
	localparam logic [7:0] OFS_WDATA   = 8'h10;
	localparam logic [7:0] OFS_LASTCMD = 8'h14;
	localparam logic [7:0] OFS_CSSTAT  = 8'h18;
	localparam logic [7:0] OFS_COUNT   = 8'h1c;
	localparam logic [7:0] OFS_DADDR   = 8'h20;
	localparam logic [7:0] OFS_SADDR   = 8'h24;
	localparam logic [7:0] OFS_CHAIN   = 8'h28;
	localparam logic [7:0] OFS_PCIID   = 8'h2c;
	localparam logic [7:0] OFS_XDONE   = 8'h30;
	localparam logic [7:0] OFS_PREP    = 8'h34;
	localparam logic [7:0] OFS_CTLW    = 8'h38;
	localparam int CTRL_BYTE    = 0;
	localparam int CTRL_SE      = 1;
	localparam int CTRL_BURST   = 2;
	localparam int CTRL_WORD    = 3;
	localparam int CTRL_CHAIN   = 4;
	localparam int CTRL_PCI     = 5;
	localparam int CTRL_DEV_LSB = 8;
	localparam logic [15:0] CTRL_RST  = 16'h0036;
	localparam logic [2:0]  IDFLG_RST = 3'b010;
	localparam logic [15:0] DATA_RST  = 16'h0000;
	localparam int CW_CHAIN = 15;
	localparam int CW_PCI   = 14;
	localparam int CW_DIR   = 13;
	localparam int CW_SE    = 11;
	localparam int CW_BURST = 0;
	localparam logic [2:0] PB_CTRL  = 3'd0;
	localparam logic [2:0] PB_P3    = 3'd3;
	localparam logic [2:0] PB_SADDR = 3'd4;
	localparam logic [2:0] PB_CHAIN = 3'd5;
	localparam logic [2:0] PB_COUNT = 3'd6;
	localparam logic [2:0] PB_DADDR = 3'd7;
	localparam int ST_BUSY  = 0;
	localparam int ST_DIR   = 1;
	localparam int ST_BURST = 2;
	localparam int ST_SE    = 3;
	localparam int ST_SPEC  = 4;
	localparam int ST_REJ   = 5;
	localparam int ST_PCI   = 6;
	localparam int ST_XFER  = 7;
	typedef enum logic [3:0] {
		C_READ = 4'h0, C_IDENT = 4'h1, C_RSTAT = 4'h2, C_WRITE = 4'h3,
		C_PREP = 4'h4, C_CTRL = 4'h5, C_DRST = 4'h6, C_START = 4'h7,
		C_STST = 4'h8, C_HALT = 4'h9, C_RSVD = 4'ha, C_CHREJ = 4'hb
	} cmd_class_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_FETCH = 3'b001, S_CHECK = 3'b010,
		S_XFER = 3'b011, S_STORE = 3'b100
	} cs_state_t;
	typedef struct packed {
		logic [7:0]  cmd;
		logic [7:0]  dev;
		logic [15:0] data;
	} imm_cmd_t;
	typedef struct packed {
		logic        done;
		logic        reject;
		logic [15:0] data;
		logic [1:0]  par;
	} cmd_rsp_t;
	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cs_req_t;
	function automatic cmd_class_t decode_cmd(input logic [7:0] c);
		cmd_class_t r;
		r = C_RSVD;
		if (c[7])
			r = (c == 8'hf0) ? C_HALT : C_CHREJ;
		else case (c[6:4])
			3'd0, 3'd1: r = C_READ;
			3'd2: r = (c[3:0] == 4'h0) ? C_IDENT : C_RSTAT;
			3'd3: r = C_RSVD;
			3'd4, 3'd5: r = C_WRITE;
			3'd6: r = (c[3:0] == 4'h0) ? C_PREP : ((c[3:0] == 4'hf) ? C_DRST : C_CTRL);
			3'd7: r = (c[3:0] == 4'he) ? C_STST : C_START;
			default: r = C_RSVD;
		endcase
		return r;
	endfunction
endpackage

// ==== hw/io_command_and_control_block_decoder.sv ====
// Command decoder and parameter block interpreter for a channel attached device
// Functional notes
// RULE_01 - Decode command byte into read, identify, status, write, prepare, control, reset, start, halt.
// RULE_02 - Device-defined modifiers pass through; fixed modifiers carry system meaning.
// RULE_03 - Issuer never sends 3X commands; device ignores them.
// RULE_04 - Start fetches the eight-word parameter block by cycle-steal reads.
// RULE_05 - Control bit 0 set means chained: continue with next block.
// RULE_06 - Control bit 1 set raises programmed interrupt after block fetch.
// RULE_07 - Control bit 2 gives direction: 0 memory to device, 1 device to memory.
// RULE_08 - Issuer sets direction one for two-way, zero for control-only blocks.
// RULE_09 - Issuer writes reserved bit 3 and unused bits as zero; unchecked.
// RULE_10 - Control bit 4 allows exception suppression with alternative action.
// RULE_11 - Control bits 8-15 are device modifier; bit 15 selects burst.
// RULE_12 - With programmed interrupt, word 3 upper byte becomes interrupt block identifier.
// RULE_13 - With suppression, word 4 is status address; residual status stored there.
// RULE_14 - With chaining, word 5 is the next block address.
// RULE_15 - Count word is unsigned byte count; word-only devices need even count.
// RULE_16 - Invalid fetched word records specification check and ends with exception.
// RULE_17 - Odd block address rejects; odd chain or status address is specification check.
// RULE_18 - Single-byte read puts byte in low byte, upper byte zero.
// RULE_19 - Every read returns correct parity on both data bytes.
// RULE_20 - Read groups 0X and 1X behave identically.
// RULE_21 - Identify word: code, controller flag, cycle-steal flag, third-party flag.
// RULE_22 - Single-byte write carries byte low; byte device ignores upper byte.
// RULE_23 - Command word holds command byte and device address; second word data.
// RULE_24 - Channel-directed commands other than halt are rejected by the channel.
// RULE_25 - No data transfer starts before all needed block words are fetched and checked.
`timescale 1ns/100ps
`default_nettype none
module io_command_and_control_block_decoder #(
	parameter int unsigned DEV_CODE = 291 // Arbitrary value
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 cmd_valid,
	input  wire iocmd_pkg::imm_cmd_t  cmd_in,
	output iocmd_pkg::cmd_rsp_t       cmd_rsp,
	output iocmd_pkg::cs_req_t        cs_out,
	input  wire logic                 cs_ack,
	input  wire logic [15:0]          cs_rdata,
	output logic                      xfer_start,
	output logic                      pci_event,
	output logic                      exc_event,
	output logic                      op_end,
	output logic                      busy
);
	generate
		if (DEV_CODE > 8191) begin : g_bad_code
			$error("DEV_CODE exceeds 13 bits");
		end
	endgenerate

	function automatic logic [1:0] odd_par(input logic [15:0] w);
		return {~^w[15:8], ~^w[7:0]};
	endfunction

	logic                 pready_ff;
	logic [31:0]          prdata_ff;
	logic                 pslverr_ff;
	logic [15:0]          ctrl_ff;
	logic [15:0]          rdata_ff;
	logic [15:0]          stword_ff;
	logic [2:0]           idflg_ff;
	logic [15:0]          wdata_ff;
	logic [15:0]          prep_ff;
	logic [15:0]          ctlw_ff;
	logic [19:0]          lastcmd_ff;
	iocmd_pkg::cmd_rsp_t  rsp_ff;
	iocmd_pkg::cs_state_t state_ff;
	iocmd_pkg::cs_req_t   cs_ff;
	logic [15:0]          pb_ff [0:7];
	logic [2:0]           idx_ff;
	logic [15:0]          base_ff;
	logic [15:0]          resid_ff;
	logic [7:0]           pciid_ff;
	logic                 spec_ff;
	logic                 rej_ff;
	logic                 pcif_ff;
	logic                 xfer_ff;
	logic                 xs_ff;
	logic                 pe_ff;
	logic                 ee_ff;
	logic                 oe_ff;

	// Bus decode
	wire apb_acc = psel && penable;
	wire apb_fin = apb_acc && pready_ff;
	wire apb_wr  = apb_fin && pwrite;
	wire [7:0] a = paddr;
	wire hit = (a == iocmd_pkg::OFS_IDENT) || (a == iocmd_pkg::OFS_RDATA) ||
		(a == iocmd_pkg::OFS_STWORD) || (a == iocmd_pkg::OFS_CTRL) ||
		(a == iocmd_pkg::OFS_WDATA) || (a == iocmd_pkg::OFS_LASTCMD) ||
		(a == iocmd_pkg::OFS_CSSTAT) || (a == iocmd_pkg::OFS_COUNT) ||
		(a == iocmd_pkg::OFS_DADDR) || (a == iocmd_pkg::OFS_SADDR) ||
		(a == iocmd_pkg::OFS_CHAIN) || (a == iocmd_pkg::OFS_PCIID) ||
		(a == iocmd_pkg::OFS_XDONE) || (a == iocmd_pkg::OFS_PREP) ||
		(a == iocmd_pkg::OFS_CTLW);
	wire wr_xdone = apb_wr && (a == iocmd_pkg::OFS_XDONE);
	wire wr_clr   = apb_wr && (a == iocmd_pkg::OFS_CSSTAT);

	// Identify word, code in the high bits
	wire [15:0] ident_w = {DEV_CODE[12:0], idflg_ff}; // RULE_21

	wire [15:0] cw = pb_ff[iocmd_pkg::PB_CTRL];
	wire chain_on = ctrl_ff[iocmd_pkg::CTRL_CHAIN] && cw[iocmd_pkg::CW_CHAIN]; // RULE_05
	wire pci_on   = ctrl_ff[iocmd_pkg::CTRL_PCI] && cw[iocmd_pkg::CW_PCI]; // RULE_06
	wire se_on    = ctrl_ff[iocmd_pkg::CTRL_SE] && cw[iocmd_pkg::CW_SE]; // RULE_10
	wire burst_on = ctrl_ff[iocmd_pkg::CTRL_BURST] && cw[iocmd_pkg::CW_BURST]; // RULE_11
	wire dir_in   = cw[iocmd_pkg::CW_DIR]; // RULE_07
	wire [15:0] cs_stat = {8'h00, xfer_ff, pcif_ff, rej_ff, spec_ff,
		se_on, burst_on, dir_in, (state_ff != iocmd_pkg::S_IDLE)};

	logic [15:0] rd_mux;
	always_comb begin
		case (a)
			iocmd_pkg::OFS_IDENT:   rd_mux = ident_w;
			iocmd_pkg::OFS_RDATA:   rd_mux = rdata_ff;
			iocmd_pkg::OFS_STWORD:  rd_mux = stword_ff;
			iocmd_pkg::OFS_CTRL:    rd_mux = ctrl_ff;
			iocmd_pkg::OFS_WDATA:   rd_mux = wdata_ff;
			iocmd_pkg::OFS_CSSTAT:  rd_mux = cs_stat;
			iocmd_pkg::OFS_COUNT:   rd_mux = pb_ff[iocmd_pkg::PB_COUNT];
			iocmd_pkg::OFS_DADDR:   rd_mux = pb_ff[iocmd_pkg::PB_DADDR];
			iocmd_pkg::OFS_SADDR:   rd_mux = pb_ff[iocmd_pkg::PB_SADDR];
			iocmd_pkg::OFS_CHAIN:   rd_mux = pb_ff[iocmd_pkg::PB_CHAIN];
			iocmd_pkg::OFS_PCIID:   rd_mux = {8'h00, pciid_ff};
			iocmd_pkg::OFS_XDONE:   rd_mux = resid_ff;
			iocmd_pkg::OFS_PREP:    rd_mux = prep_ff;
			iocmd_pkg::OFS_CTLW:    rd_mux = ctlw_ff;
			default:                rd_mux = 16'h0000;
		endcase
	end
	wire [31:0] rd_word = (a == iocmd_pkg::OFS_LASTCMD) ? {12'h000, lastcmd_ff} : {16'h0000, rd_mux};

	// One wait state on every access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= apb_acc && !pready_ff;
			prdata_ff  <= (apb_acc && !pready_ff && !pwrite) ? rd_word : 32'h0000_0000;
			pslverr_ff <= apb_acc && !pready_ff && !hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff   <= iocmd_pkg::CTRL_RST;
			rdata_ff  <= iocmd_pkg::DATA_RST;
			stword_ff <= iocmd_pkg::DATA_RST;
			idflg_ff  <= iocmd_pkg::IDFLG_RST;
		end else if (apb_wr) begin
			if (a == iocmd_pkg::OFS_CTRL)
				ctrl_ff <= pwdata[15:0];
			if (a == iocmd_pkg::OFS_RDATA)
				rdata_ff <= pwdata[15:0];
			if (a == iocmd_pkg::OFS_STWORD)
				stword_ff <= pwdata[15:0];
			if (a == iocmd_pkg::OFS_IDENT)
				idflg_ff <= pwdata[2:0];
		end
	end

	// Immediate command decode
	wire [7:0] dev_addr = ctrl_ff[iocmd_pkg::CTRL_DEV_LSB +: 8];
	wire byte_mode = ctrl_ff[iocmd_pkg::CTRL_BYTE];
	wire iocmd_pkg::cmd_class_t cls = iocmd_pkg::decode_cmd(cmd_in.cmd); // RULE_01 RULE_02 RULE_20
	wire mine = cmd_valid && (cmd_in.dev == dev_addr); // RULE_23
	// Reserved and channel-directed codes other than halt are left to the channel
	wire served = mine && (cls != iocmd_pkg::C_RSVD) && (cls != iocmd_pkg::C_CHREJ); // RULE_03 RULE_24
	wire do_halt = cmd_valid && (cls == iocmd_pkg::C_HALT);
	wire do_drst = mine && (cls == iocmd_pkg::C_DRST);
	wire abort = do_halt || do_drst;
	wire is_start = mine && ((cls == iocmd_pkg::C_START) || (cls == iocmd_pkg::C_STST));
	wire start_bad = is_start && ((state_ff != iocmd_pkg::S_IDLE) || cmd_in.data[0]); // RULE_17
	wire start_ok = is_start && !start_bad;
	wire [15:0] byte_low = {8'h00, cmd_in.data[7:0]};

	logic [15:0] rsp_data;
	always_comb begin
		case (cls)
			iocmd_pkg::C_READ:  rsp_data = byte_mode ? {8'h00, rdata_ff[7:0]} : rdata_ff; // RULE_18
			iocmd_pkg::C_IDENT: rsp_data = ident_w;
			iocmd_pkg::C_RSTAT: rsp_data = stword_ff;
			default:            rsp_data = 16'h0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_ff     <= '0;
			wdata_ff   <= iocmd_pkg::DATA_RST;
			prep_ff    <= iocmd_pkg::DATA_RST;
			ctlw_ff    <= iocmd_pkg::DATA_RST;
			lastcmd_ff <= 20'h00000;
		end else begin
			rsp_ff.done   <= served && !do_halt;
			rsp_ff.reject <= start_bad;
			rsp_ff.data   <= served ? rsp_data : 16'h0000;
			rsp_ff.par    <= odd_par(served ? rsp_data : 16'h0000); // RULE_19
			if (served)
				lastcmd_ff <= {cls, cmd_in.cmd, cmd_in.dev};
			if (served && cls == iocmd_pkg::C_WRITE)
				wdata_ff <= byte_mode ? byte_low : cmd_in.data; // RULE_22
			if (served && cls == iocmd_pkg::C_PREP)
				prep_ff <= cmd_in.data;
			if (served && cls == iocmd_pkg::C_CTRL)
				ctlw_ff <= cmd_in.data;
		end
	end

	// Parameter block checks after the fetch
	wire odd_chain = chain_on && pb_ff[iocmd_pkg::PB_CHAIN][0]; // RULE_17
	wire odd_stat  = se_on && pb_ff[iocmd_pkg::PB_SADDR][0]; // RULE_17
	wire odd_count = ctrl_ff[iocmd_pkg::CTRL_WORD] && pb_ff[iocmd_pkg::PB_COUNT][0]; // RULE_15
	wire spec_bad  = odd_chain || odd_stat || odd_count; // RULE_16
	wire [15:0] next_addr = base_ff + {12'h000, idx_ff + 3'd1, 1'b0};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= iocmd_pkg::S_IDLE;
			cs_ff    <= '0;
			idx_ff   <= 3'd0;
			base_ff  <= 16'h0000;
			resid_ff <= 16'h0000;
			pciid_ff <= 8'h00;
			spec_ff  <= 1'b0;
			rej_ff   <= 1'b0;
			pcif_ff  <= 1'b0;
			xfer_ff  <= 1'b0;
			xs_ff    <= 1'b0;
			pe_ff    <= 1'b0;
			ee_ff    <= 1'b0;
			oe_ff    <= 1'b0;
			for (int i = 0; i < 8; i++)
				pb_ff[i] <= 16'h0000;
		end else begin
			xs_ff <= 1'b0;
			pe_ff <= 1'b0;
			ee_ff <= 1'b0;
			oe_ff <= 1'b0;
			// Set wins over a clear in the same cycle
			if (wr_clr) begin
				spec_ff <= spec_ff && !pwdata[iocmd_pkg::ST_SPEC];
				rej_ff  <= rej_ff && !pwdata[iocmd_pkg::ST_REJ];
				pcif_ff <= pcif_ff && !pwdata[iocmd_pkg::ST_PCI];
			end
			if (start_bad)
				rej_ff <= 1'b1;
			if (xfer_ff && wr_xdone)
				resid_ff <= pwdata[15:0];
			if (abort) begin
				state_ff <= iocmd_pkg::S_IDLE;
				cs_ff    <= '0;
				xfer_ff  <= 1'b0;
			end else begin
				case (state_ff)
					iocmd_pkg::S_IDLE: begin
						if (start_ok) begin
							base_ff  <= cmd_in.data;
							idx_ff   <= 3'd0;
							cs_ff    <= '{req: 1'b1, we: 1'b0, addr: cmd_in.data, wdata: 16'h0000}; // RULE_04
							state_ff <= iocmd_pkg::S_FETCH;
						end
					end
					iocmd_pkg::S_FETCH: begin
						if (cs_ack) begin
							pb_ff[idx_ff] <= cs_rdata;
							idx_ff        <= idx_ff + 3'd1;
							cs_ff.addr    <= next_addr;
							if (idx_ff == 3'd7) begin
								cs_ff.req <= 1'b0;
								state_ff  <= iocmd_pkg::S_CHECK;
							end
						end
					end
					iocmd_pkg::S_CHECK: begin
						if (pci_on) begin
							pe_ff    <= 1'b1; // RULE_06
							pcif_ff  <= 1'b1;
							pciid_ff <= pb_ff[iocmd_pkg::PB_P3][15:8]; // RULE_12
						end
						if (spec_bad) begin
							spec_ff  <= 1'b1; // RULE_16
							ee_ff    <= 1'b1;
							oe_ff    <= 1'b1;
							state_ff <= iocmd_pkg::S_IDLE;
						end else begin
							xs_ff    <= 1'b1; // RULE_25
							xfer_ff  <= 1'b1;
							state_ff <= iocmd_pkg::S_XFER;
						end
					end
					iocmd_pkg::S_XFER: begin
						// Software reports the end of the data phase
						if (wr_xdone) begin
							xfer_ff <= 1'b0;
							if (se_on) begin
								cs_ff <= '{req: 1'b1, we: 1'b1, addr: pb_ff[iocmd_pkg::PB_SADDR],
									wdata: pwdata[15:0]}; // RULE_13
								state_ff <= iocmd_pkg::S_STORE;
							end else if (chain_on) begin
								base_ff  <= pb_ff[iocmd_pkg::PB_CHAIN]; // RULE_14
								idx_ff   <= 3'd0;
								cs_ff    <= '{req: 1'b1, we: 1'b0, addr: pb_ff[iocmd_pkg::PB_CHAIN], wdata: 16'h0000};
								state_ff <= iocmd_pkg::S_FETCH;
							end else begin
								oe_ff    <= 1'b1;
								state_ff <= iocmd_pkg::S_IDLE;
							end
						end
					end
					iocmd_pkg::S_STORE: begin
						if (cs_ack) begin
							if (chain_on) begin
								base_ff  <= pb_ff[iocmd_pkg::PB_CHAIN]; // RULE_05
								idx_ff   <= 3'd0;
								cs_ff    <= '{req: 1'b1, we: 1'b0, addr: pb_ff[iocmd_pkg::PB_CHAIN], wdata: 16'h0000};
								state_ff <= iocmd_pkg::S_FETCH;
							end else begin
								cs_ff    <= '0;
								oe_ff    <= 1'b1;
								state_ff <= iocmd_pkg::S_IDLE;
							end
						end
					end
					default: state_ff <= iocmd_pkg::S_IDLE;
				endcase
			end
		end
	end

	// Busy mirrors a flop so that it stays glitch free
	logic busy_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_ff <= 1'b0;
		else
			busy_ff <= !abort && (start_ok || ((state_ff != iocmd_pkg::S_IDLE) && !oe_ff) ||
				(state_ff == iocmd_pkg::S_FETCH) || (state_ff == iocmd_pkg::S_XFER));
	end

	assign prdata     = prdata_ff;
	assign pready     = pready_ff;
	assign pslverr    = pslverr_ff;
	assign cmd_rsp    = rsp_ff;
	assign cs_out     = cs_ff;
	assign xfer_start = xs_ff;
	assign pci_event  = pe_ff;
	assign exc_event  = ee_ff;
	assign op_end     = oe_ff;
	assign busy       = busy_ff;
endmodule
`default_nettype wire

// ==== test/iocmd_chk.sv ====
// Port-level checker for the command decoder
`timescale 1ns/100ps
`default_nettype none
module iocmd_chk #(
	parameter int unsigned DEV_CODE = 291
) (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic                pready,
	input wire logic                cmd_valid,
	input wire iocmd_pkg::imm_cmd_t cmd_in,
	input wire iocmd_pkg::cmd_rsp_t cmd_rsp,
	input wire iocmd_pkg::cs_req_t  cs_out,
	input wire logic                cs_ack,
	input wire logic                xfer_start,
	input wire logic                pci_event,
	input wire logic                exc_event,
	input wire logic                op_end,
	input wire logic                busy
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [7:0] dev_ff;
	wire        ctrl_wr = psel && penable && pready && pwrite && (paddr == iocmd_pkg::OFS_CTRL);
	wire        served  = cmd_valid && (cmd_in.dev == dev_ff);
	wire        start   = served && (cmd_in.cmd[7:4] == 4'h7) && !busy && !cs_out.req;
	// Own device address copy tracks moves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dev_ff <= iocmd_pkg::CTRL_RST[15:8];
		else if (ctrl_wr)
			dev_ff <= pwdata[15:8];
	end
	sequence read_req;
		served && (cmd_in.cmd[7:5] == 3'b000);
	endsequence
	// Commands excluded: an abort right at the last word is legal
	sequence fetch_end;
		busy && cs_ack && !cs_out.we && !cmd_valid ##1 !cs_out.req && !cmd_valid;
	endsequence
	read_done_a: assert property (read_req |=> cmd_rsp.done && !cmd_rsp.reject) else $error("read unanswered");
	ident_word_a: assert property (served && cmd_in.cmd == 8'h20 |=> cmd_rsp.data[15:3] == DEV_CODE[12:0])
		else $error("bad identify code");
	rsvd_quiet_a: assert property (cmd_valid && cmd_in.cmd[7:4] == 4'h3 |=> !cmd_rsp.done && !cmd_rsp.reject)
		else $error("reserved answered");
	halt_abort_a: assert property (cmd_valid && cmd_in.cmd == 8'hf0 |=> !cs_out.req && !cmd_rsp.done)
		else $error("halt not aborting");
	rsp_parity_a: assert property (cmd_rsp.done |-> cmd_rsp.par == {~^cmd_rsp.data[15:8], ~^cmd_rsp.data[7:0]})
		else $error("bad parity");
	odd_block_a: assert property (start && cmd_in.data[0] |=> cmd_rsp.reject && !cs_out.req)
		else $error("odd block taken");
	fetch_first_a: assert property (start && !cmd_in.data[0] |=> cs_out.req && !cs_out.we && cs_out.addr == $past(cmd_in.data))
		else $error("bad first fetch");
	addr_step_a: assert property (cs_ack && !cs_out.we |=> !cs_out.req || cs_out.addr == $past(cs_out.addr) + 16'd2)
		else $error("bad fetch step");
	go_after_fetch_a: assert property (fetch_end |=> xfer_start || exc_event) else $error("no outcome after fetch");
	pci_with_go_a: assert property (pci_event |-> xfer_start || exc_event) else $error("pci off fetch end");
	exc_ends_a: assert property (exc_event |-> op_end && !xfer_start) else $error("exception not ending");
endmodule
bind io_command_and_control_block_decoder iocmd_chk #(.DEV_CODE(DEV_CODE)) i_iocmd_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .cmd_valid, .cmd_in,
	.cmd_rsp, .cs_out, .cs_ack, .xfer_start, .pci_event, .exc_event, .op_end, .busy
);
`default_nettype wire

// ==== test/cs_mem_model.sv ====
// Main storage partner answering cycle-steal requests
`timescale 1ns/100ps
`default_nettype none
module cs_mem_model (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire iocmd_pkg::cs_req_t cs_out,
	input  wire logic               slow,
	output logic                    cs_ack,
	output logic [15:0]             cs_rdata
);
	logic [15:0] mem [0:255];
	logic [2:0]  wait_ff;
	wire  [7:0]  idx = cs_out.addr[8:1];
	// At least one idle cycle between acks, so the address can advance
	wire         go  = cs_out.req && !cs_ack && (wait_ff >= (slow ? 3'd4 : 3'd1));
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_ff <= 3'd0;
			cs_ack <= 1'b0;
			cs_rdata <= 16'h0000;
		end else begin
			cs_ack <= go;
			wait_ff <= (go || !cs_out.req) ? 3'd0 : wait_ff + 3'd1;
			// Outside an answer the bus inverts its last word every cycle
			cs_rdata <= go ? mem[idx] : ~cs_rdata;
			if (go && cs_out.we)
				mem[idx] <= cs_out.wdata;
		end
	end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Bench driving the command decoder with a storage partner
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [7:0]  cmd;
		logic [15:0] din;
		logic        done;
		logic [15:0] rsp;
		logic [7:0]  ofs;
		logic [15:0] rval;
	} row_t;
	localparam int unsigned DEV = 291; // Arbitrary value
	localparam logic [15:0] IDW = {13'(DEV), 3'b011};
	logic                pclk = 1'b0;
	logic                presetn = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [7:0]          paddr = 8'h00;
	logic [31:0]         pwdata = 32'h0;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                cmd_valid = 1'b0;
	iocmd_pkg::imm_cmd_t cmd_in = '0;
	iocmd_pkg::cmd_rsp_t cmd_rsp;
	iocmd_pkg::cmd_rsp_t rsp;
	iocmd_pkg::cs_req_t  cs_out;
	logic                cs_ack;
	logic [15:0]         cs_rdata;
	logic                xfer_start;
	logic                pci_event;
	logic                exc_event;
	logic                op_end;
	logic                busy;
	logic                slow = 1'b1;
	logic [31:0]         rdv;
	int                  errors = 0;
	int                  checks = 0;
	int                  evc [4] = '{0, 0, 0, 0};
	int                  base [4] = '{0, 0, 0, 0};
	// Reads, writes, stores, ignored codes, halt, then device reset last
	row_t rows [11] = '{'{8'h05, 16'h0, 1'b1, 16'h1234, 8'hff, 16'h0}, '{8'h1a, 16'h0, 1'b1, 16'h1234, 8'hff, 16'h0},
		'{8'h20, 16'h0, 1'b1, IDW, 8'hff, 16'h0}, '{8'h2c, 16'h0, 1'b1, 16'h5a5a, 8'hff, 16'h0},
		'{8'h4a, 16'h8421, 1'b1, 16'h0, 8'h10, 16'h8421}, '{8'h60, 16'h00c3, 1'b1, 16'h0, 8'h34, 16'h00c3},
		'{8'h6c, 16'h0f0f, 1'b1, 16'h0, 8'h38, 16'h0f0f}, '{8'h35, 16'h0, 1'b0, 16'h0, 8'hff, 16'h0},
		'{8'h85, 16'h0, 1'b0, 16'h0, 8'hff, 16'h0}, '{8'hf0, 16'h0, 1'b0, 16'h0, 8'hff, 16'h0},
		'{8'h6f, 16'h0, 1'b1, 16'h0, 8'hff, 16'h0}};
	// Control register, control word, status address, chain address, count
	logic [79:0] spec [3] = '{80'h0036_8000_0000_0121_0002, 80'h0036_0800_0041_0000_0002, 80'h003e_0000_0000_0000_0003};
	io_command_and_control_block_decoder #(.DEV_CODE(DEV)) i_io_command_and_control_block_decoder (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_valid,
		.cmd_in, .cmd_rsp, .cs_out, .cs_ack, .cs_rdata, .xfer_start, .pci_event, .exc_event, .op_end, .busy
	);
	cs_mem_model i_cs_mem_model (.pclk, .presetn, .cs_out, .slow, .cs_ack, .cs_rdata);
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		evc[0] += int'(xfer_start === 1'b1);
		evc[1] += int'(pci_event === 1'b1);
		evc[2] += int'(exc_event === 1'b1);
		evc[3] += int'(op_end === 1'b1);
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			give_verdict();
		end
		rdv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] x);
		apb(1'b0, a, 32'h0);
		chk(nm, rdv, {16'h0, x});
	endtask
	task automatic issue(input logic [7:0] c, input logic [15:0] d);
		@(posedge pclk);
		cmd_valid <= 1'b1;
		cmd_in <= '{cmd: c, dev: 8'h00, data: d};
		@(posedge pclk);
		cmd_valid <= 1'b0;
		cmd_in <= ~cmd_in;
		@(posedge pclk);
		rsp = cmd_rsp;
	endtask
	task automatic wait_ev(input int s, input int k);
		int n;
		n = 0;
		while (evc[s] - base[s] < k && n < 300) begin
			@(posedge pclk);
			n++;
		end
		if (evc[s] - base[s] < k) begin
			errors++;
			give_verdict();
		end
	endtask
	task automatic load_blk(input logic [15:0] a, input logic [15:0] cw, w3, w4, w5, cnt, da);
		logic [15:0] w [8];
		w = '{cw, 16'h0, 16'h0, w3, w4, w5, cnt, da};
		for (int k = 0; k < 8; k++)
			i_cs_mem_model.mem[a[8:1] + 8'(k)] = w[k];
		base = evc;
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rchk("ctrl reset", iocmd_pkg::OFS_CTRL, iocmd_pkg::CTRL_RST);
		rchk("ident reset", iocmd_pkg::OFS_IDENT, {13'(DEV), iocmd_pkg::IDFLG_RST});
		rchk("unmapped", 8'h3c, 16'h0);
		chk("unmapped err", {31'h0, pslverr}, 32'h1);
		apb(1'b1, iocmd_pkg::OFS_IDENT, 32'h3);
		apb(1'b1, iocmd_pkg::OFS_RDATA, 32'h1234);
		apb(1'b1, iocmd_pkg::OFS_STWORD, 32'h5a5a);
		foreach (rows[i]) begin
			issue(rows[i].cmd, rows[i].din);
			chk("done", {31'h0, rsp.done}, {31'h0, rows[i].done});
			if (rows[i].cmd < 8'h30)
				chk("read data", {16'h0, rsp.data}, {16'h0, rows[i].rsp});
			if (rows[i].ofs != 8'hff)
				rchk("stored", rows[i].ofs, rows[i].rval);
		end
		apb(1'b1, iocmd_pkg::OFS_CTRL, 32'h0037);
		apb(1'b1, iocmd_pkg::OFS_RDATA, 32'hbeef);
		issue(8'h05, 16'h0);
		chk("byte read", {16'h0, rsp.data}, 32'h00ef);
		issue(8'h45, 16'h12ab);
		rchk("byte write", iocmd_pkg::OFS_WDATA, 16'h00ab);
		apb(1'b1, iocmd_pkg::OFS_CTRL, 32'h0036);
		load_blk(16'h0100, 16'h6001, 16'ha500, 16'h0, 16'h0, 16'h0010, 16'h0400);
		issue(8'h70, 16'h0100);
		wait_ev(0, 1);
		chk("pci", 32'(evc[1] - base[1]), 32'h1);
		rchk("status", iocmd_pkg::OFS_CSSTAT, 16'h00c7);
		rchk("block id", iocmd_pkg::OFS_PCIID, 16'h00a5);
		rchk("count", iocmd_pkg::OFS_COUNT, 16'h0010);
		issue(8'h70, 16'h0100);
		chk("busy reject", {31'h0, rsp.reject}, 32'h1);
		apb(1'b1, iocmd_pkg::OFS_XDONE, 32'h0);
		wait_ev(3, 1);
		apb(1'b1, iocmd_pkg::OFS_CSSTAT, 32'h70);
		slow <= 1'b0;
		load_blk(16'h0120, 16'h0000, 16'h0, 16'h0, 16'h0, 16'h0002, 16'h0500);
		load_blk(16'h0100, 16'h8800, 16'h0, 16'h0040, 16'h0120, 16'h0004, 16'h0400);
		issue(8'h7e, 16'h0100);
		wait_ev(0, 1);
		rchk("se status", iocmd_pkg::OFS_CSSTAT, 16'h0089);
		apb(1'b1, iocmd_pkg::OFS_XDONE, 32'h0bad);
		wait_ev(0, 2);
		chk("residual", {16'h0, i_cs_mem_model.mem[8'h20]}, 32'h0bad);
		rchk("chained count", iocmd_pkg::OFS_COUNT, 16'h0002);
		apb(1'b1, iocmd_pkg::OFS_XDONE, 32'h0);
		wait_ev(3, 1);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, iocmd_pkg::OFS_CTRL, {16'h0, spec[i][79:64]});
			load_blk(16'h0100, spec[i][63:48], 16'h0, spec[i][47:32], spec[i][31:16], spec[i][15:0], 16'h0400);
			issue(8'h70, 16'h0100);
			wait_ev(3, 1);
			chk("exception", 32'(evc[2] - base[2]), 32'h1);
			chk("no transfer", 32'(evc[0] - base[0]), 32'h0);
			apb(1'b0, iocmd_pkg::OFS_CSSTAT, 32'h0);
			chk("spec flag", {31'h0, rdv[4]}, 32'h1);
			apb(1'b1, iocmd_pkg::OFS_CSSTAT, 32'h10);
		end
		apb(1'b1, iocmd_pkg::OFS_CTRL, 32'h0036);
		issue(8'h70, 16'h0101);
		chk("odd block", {31'h0, rsp.reject}, 32'h1);
		slow <= 1'b1;
		load_blk(16'h0100, 16'h6001, 16'ha500, 16'h0, 16'h0, 16'h0010, 16'h0400);
		issue(8'h70, 16'h0100);
		issue(8'hf0, 16'h0);
		chk("halt req", {31'h0, cs_out.req}, 32'h0);
		repeat (20) @(posedge pclk);
		chk("halt idle", {31'h0, busy}, 32'h0);
		chk("halt no go", 32'(evc[0] - base[0]), 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
